// ===== scc_pkg.sv
// scc_pkg: constants and types for the security context cache
// assumes one 25 MHz clock domain and active-low async reset
package scc_pkg;
    localparam int unsigned SCC_ENTRIES    = 64;  // resident contexts
    localparam int unsigned SCC_WAYS       = 4;   // entries per set
    localparam int unsigned SCC_SETS       = 16;  // chosen by id[3:0]
    localparam int unsigned SCC_SET_W      = 4;
    localparam int unsigned SCC_WAY_W      = 2;
    localparam int unsigned SCC_PTR_W      = 32;
    localparam int unsigned SCC_ID_W       = 16;
    localparam int unsigned SCC_IDX_W      = 15;
    localparam int unsigned SCC_TIER_BIT   = 15;  // pinning flag position
    localparam int unsigned SCC_FLAG_W     = 2;
    localparam int unsigned SCC_FLAG_EVICT = 0;   // force eviction
    localparam int unsigned SCC_FLAG_NOPROC = 1;  // control only, no packet
    localparam int unsigned SCC_CTX_BYTES  = 320; // context size in memory
    localparam int unsigned SCC_WORD_BYTES = 4;
    localparam int unsigned SCC_CTX_WORDS  = SCC_CTX_BYTES / SCC_WORD_BYTES;
    localparam int unsigned SCC_CNT_W      = 7;
    localparam logic [1:0]  SCC_AGE_RST    = 2'h0;

    typedef enum logic [1:0] {
        SCC_IDLE  = 2'b00,
        SCC_FETCH = 2'b01,
        SCC_FILL  = 2'b10,
        SCC_DONE  = 2'b11
    } scc_state_t;
endpackage : scc_pkg

// ===== scc_set_lookup.sv
// scc_set_lookup: compares one identifier against the four ways of a set
// assumes tags, valid, pin and age bits are presented for the chosen set
`timescale 1ns/100ps
module scc_set_lookup
    import scc_pkg::*;
(
    input  wire logic [SCC_IDX_W-1:0]           i_idx,
    input  wire logic [SCC_WAYS*SCC_IDX_W-1:0]  i_tags,
    input  wire logic [SCC_WAYS-1:0]            i_valid,
    input  wire logic [SCC_WAYS-1:0]            i_pin,
    input  wire logic [SCC_WAYS-1:0]            i_busy,
    input  wire logic [SCC_WAYS*2-1:0]          i_age,
    output logic                                o_hit,
    output logic      [SCC_WAY_W-1:0]           o_hit_way,
    output logic                                o_vict_ok,
    output logic      [SCC_WAY_W-1:0]           o_vict_way,
    output logic      [2:0]                     o_pin_cnt
);
    logic [SCC_WAYS-1:0] match;

    // four parallel tag compares
    genvar g;
    generate
        for (g = 0; g < SCC_WAYS; g++)
        begin : g_cmp
            assign match[g] = i_valid[g] &&
                (i_tags[g*SCC_IDX_W +: SCC_IDX_W] == i_idx);
        end
    endgenerate

    // hit select, first empty slot, else oldest unpinned idle entry
    always_comb
    begin
        logic [1:0] best_age;
        logic       found_empty;
        best_age    = 2'h0;
        found_empty = 1'b0;
        o_hit       = 1'b0;
        o_hit_way   = '0;
        o_vict_ok   = 1'b0;
        o_vict_way  = '0;
        o_pin_cnt   = 3'h0;
        for (int w = 0; w < SCC_WAYS; w++)
        begin
            if (match[w] && !o_hit)
            begin
                o_hit     = 1'b1;
                o_hit_way = SCC_WAY_W'(w);
            end
            if (i_valid[w] && i_pin[w])
                o_pin_cnt = o_pin_cnt + 3'h1;
        end
        for (int w = 0; w < SCC_WAYS; w++)
        begin
            if (!i_valid[w] && !found_empty)
            begin
                found_empty = 1'b1;
                o_vict_ok   = 1'b1;
                o_vict_way  = SCC_WAY_W'(w);
            end
        end
        if (!found_empty)
        begin
            for (int w = 0; w < SCC_WAYS; w++)
            begin
                if (!i_pin[w] && !i_busy[w] &&
                    (!o_vict_ok || i_age[w*2 +: 2] >= best_age))
                begin
                    o_vict_ok  = 1'b1;
                    o_vict_way = SCC_WAY_W'(w);
                    best_age   = i_age[w*2 +: 2];
                end
            end
        end
    end
endmodule : scc_set_lookup

// ===== scc_cache.sv
// scc_cache: security context cache with host memory fetch on miss
// assumes memory returns read words in order with a valid strobe,
// and the engine takes the dispatched packet while o_disp_valid is high
`timescale 1ns/100ps

// Overview of operation
// R01: hold at most 64 contexts resident
// R02: hit dispatches at once from cache
// R03: miss fetches, inserts, then dispatches
// R04: memory read only on a miss
// R05: full set evicts to make room
// R06: request has pointer, identifier and flags
// R07: identifier top bit pins, rest indexes
// R08: pinned entries never auto evicted
// R09: host may force evict any entry
// R10: unpinned entries stay until displaced
// R11: requester gives 64-byte aligned pointers
// R12: host holds 320-byte aligned regions
// R13: packet flags may force eviction
// R14: four low id bits select set
// R15: compare against all four ways
// R16: first empty, else LRU unpinned idle
// R17: pin ignored when three others pinned
// R18: hold packet until context complete
// R19: evicting absent id changes nothing
module scc_cache
    import scc_pkg::*;
(
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_b,
    input  wire logic                          i_req_valid,
    input  wire logic [scc_pkg::SCC_PTR_W-1:0] i_req_ptr,
    input  wire logic [scc_pkg::SCC_ID_W-1:0]  i_req_id,
    input  wire logic [scc_pkg::SCC_FLAG_W-1:0] i_req_flags,
    input  wire logic                          i_mem_ready,
    input  wire logic                          i_mem_rvalid,
    input  wire logic [31:0]                   i_mem_rdata,
    input  wire logic                          i_disp_ready,
    input  wire logic                          i_done_valid,
    input  wire logic [5:0]                    i_done_slot,
    output logic                               o_req_ready,
    output logic                               o_mem_rd,
    output logic      [scc_pkg::SCC_PTR_W-1:0] o_mem_addr,
    output logic      [6:0]                    o_mem_words,
    output logic                               o_disp_valid,
    output logic      [5:0]                    o_disp_slot,
    output logic                               o_disp_hit,
    output logic                               o_wr_valid,
    output logic      [5:0]                    o_wr_slot,
    output logic      [6:0]                    o_wr_word,
    output logic      [31:0]                   o_wr_data
);
    import scc_pkg::*;

    // per-entry tag store; slot = set*4 + way, 64 in total
    logic [SCC_IDX_W-1:0] tag_q   [SCC_ENTRIES];
    logic [SCC_ENTRIES-1:0] valid_q;
    logic [SCC_ENTRIES-1:0] pin_q;
    logic [SCC_ENTRIES-1:0] busy_q;
    logic [1:0]           age_q   [SCC_ENTRIES];

    scc_state_t              state_q;
    logic [SCC_PTR_W-1:0]    ptr_q;
    logic [SCC_ID_W-1:0]     id_q;
    logic [SCC_FLAG_W-1:0]   flags_q;
    logic [SCC_CNT_W-1:0]    cnt_q;
    logic [5:0]              slot_q;

    logic [SCC_SET_W-1:0]    set_sel;
    logic [SCC_WAYS*SCC_IDX_W-1:0] set_tags;
    logic [SCC_WAYS-1:0]     set_valid;
    logic [SCC_WAYS-1:0]     set_pin;
    logic [SCC_WAYS-1:0]     set_busy;
    logic [SCC_WAYS*2-1:0]   set_age;
    logic                    hit;
    logic [SCC_WAY_W-1:0]    hit_way;
    logic                    vict_ok;
    logic [SCC_WAY_W-1:0]    vict_way;
    logic [2:0]              pin_cnt;
    logic                    evict_req;
    logic                    take;
    logic                    touch;
    logic [5:0]              touch_slot;

    // R14 set select from low id bits
    assign set_sel   = id_q[SCC_SET_W-1:0];
    assign evict_req = flags_q[SCC_FLAG_EVICT];

    // gather the four ways of the chosen set
    genvar g;
    generate
        for (g = 0; g < SCC_WAYS; g++)
        begin : g_set
            assign set_tags[g*SCC_IDX_W +: SCC_IDX_W] = tag_q[{set_sel, 2'(g)}];
            assign set_valid[g] = valid_q[{set_sel, 2'(g)}];
            assign set_pin[g]   = pin_q[{set_sel, 2'(g)}];
            assign set_busy[g]  = busy_q[{set_sel, 2'(g)}];
            assign set_age[g*2 +: 2] = age_q[{set_sel, 2'(g)}];
        end
    endgenerate

    // R15 compare all four ways
    scc_set_lookup u_lookup (
        .i_idx      (id_q[SCC_IDX_W-1:0]),
        .i_tags     (set_tags),
        .i_valid    (set_valid),
        .i_pin      (set_pin),
        .i_busy     (set_busy),
        .i_age      (set_age),
        .o_hit      (hit),
        .o_hit_way  (hit_way),
        .o_vict_ok  (vict_ok),
        .o_vict_way (vict_way),
        .o_pin_cnt  (pin_cnt)
    );

    // R06 request accepted with pointer, id and flags
    assign take = i_req_valid && o_req_ready;

    // capture request
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ptr_q   <= '0;
            id_q    <= '0;
            flags_q <= '0;
        end
        else if (take)
        begin
            ptr_q   <= i_req_ptr;
            id_q    <= i_req_id;
            flags_q <= i_req_flags;
        end
    end

    // sequencer: decide in FETCH state one cycle after capture
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q      <= SCC_IDLE;
            o_req_ready  <= 1'b1;
            o_mem_rd     <= 1'b0;
            o_mem_addr   <= '0;
            o_mem_words  <= '0;
            o_disp_valid <= 1'b0;
            o_disp_slot  <= '0;
            o_disp_hit   <= 1'b0;
            cnt_q        <= '0;
            slot_q       <= '0;
        end
        else
        begin
            case (state_q)
                SCC_IDLE:
                begin
                    if (take)
                    begin
                        o_req_ready <= 1'b0;
                        state_q     <= SCC_FETCH;
                    end
                end
                SCC_FETCH:
                begin
                    if (evict_req || flags_q[SCC_FLAG_NOPROC])
                    begin
                        // R13 control-only request ends here
                        o_req_ready <= 1'b1;
                        state_q     <= SCC_IDLE;
                    end
                    else if (hit)
                    begin
                        // R02 hit dispatches immediately
                        o_disp_valid <= 1'b1;
                        o_disp_slot  <= {set_sel, hit_way};
                        o_disp_hit   <= 1'b1;
                        state_q      <= SCC_DONE;
                    end
                    else if (vict_ok)
                    begin
                        // R04 memory read only on miss
                        o_mem_rd    <= 1'b1;
                        o_mem_addr  <= ptr_q;
                        o_mem_words <= SCC_CNT_W'(SCC_CTX_WORDS);
                        slot_q      <= {set_sel, vict_way};
                        cnt_q       <= '0;
                        state_q     <= SCC_FILL;
                    end
                end
                SCC_FILL:
                begin
                    if (o_mem_rd && i_mem_ready)
                        o_mem_rd <= 1'b0;
                    // R18 hold packet until last word
                    if (i_mem_rvalid)
                    begin
                        cnt_q <= cnt_q + 7'h01;
                        if (cnt_q == SCC_CNT_W'(SCC_CTX_WORDS - 1))
                        begin
                            // R03 dispatch after insertion
                            o_disp_valid <= 1'b1;
                            o_disp_slot  <= slot_q;
                            o_disp_hit   <= 1'b0;
                            state_q      <= SCC_DONE;
                        end
                    end
                end
                SCC_DONE:
                begin
                    if (i_disp_ready)
                    begin
                        o_disp_valid <= 1'b0;
                        o_req_ready  <= 1'b1;
                        state_q      <= SCC_IDLE;
                    end
                end
                default:
                begin
                    state_q     <= SCC_IDLE;
                    o_req_ready <= 1'b1;
                end
            endcase
        end
    end

    // context words written to local storage
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_wr_valid <= 1'b0;
            o_wr_slot  <= '0;
            o_wr_word  <= '0;
            o_wr_data  <= '0;
        end
        else
        begin
            o_wr_valid <= (state_q == SCC_FILL) && i_mem_rvalid;
            o_wr_slot  <= slot_q;
            o_wr_word  <= cnt_q;
            o_wr_data  <= i_mem_rdata;
        end
    end

    assign touch = (state_q == SCC_FETCH) && !evict_req &&
                   !flags_q[SCC_FLAG_NOPROC] && (hit || vict_ok);
    assign touch_slot = hit ? {set_sel, hit_way} : {set_sel, vict_way};

    // R01 tag store of 64 entries, pin and eviction bookkeeping
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            valid_q <= '0;
            pin_q   <= '0;
            busy_q  <= '0;
            for (int e = 0; e < SCC_ENTRIES; e++)
            begin
                tag_q[e] <= '0;
                age_q[e] <= SCC_AGE_RST;
            end
        end
        else
        begin
            // engine release of an active entry
            if (i_done_valid)
                busy_q[i_done_slot] <= 1'b0;
            // R09 R13 forced eviction, pinned or not
            // R19 absent id leaves store untouched
            if ((state_q == SCC_FETCH) && evict_req && hit)
            begin
                valid_q[{set_sel, hit_way}] <= 1'b0;
                pin_q[{set_sel, hit_way}]   <= 1'b0;
            end
            if (touch)
            begin
                // R10 LRU ageing, entries stay until displaced
                for (int w = 0; w < SCC_WAYS; w++)
                begin
                    if (age_q[{set_sel, 2'(w)}] != 2'h3)
                        age_q[{set_sel, 2'(w)}] <=
                            age_q[{set_sel, 2'(w)}] + 2'h1;
                end
                age_q[touch_slot]  <= 2'h0;
                busy_q[touch_slot] <= 1'b1;
                if (!hit)
                begin
                    // R05 R16 fill chosen empty or LRU way
                    // R08 victim never pinned
                    valid_q[touch_slot] <= 1'b1;
                    tag_q[touch_slot]   <= id_q[SCC_IDX_W-1:0];
                    // R07 R17 pin unless three already pinned
                    pin_q[touch_slot]   <= id_q[SCC_TIER_BIT] &&
                                           (pin_cnt < 3'h3);
                end
            end
        end
    end
endmodule : scc_cache

// ===== scc_cache_asserts.sv
// scc_cache_asserts: port checks for the context cache
// assumes binding onto scc_cache, one clock, active-low reset
`timescale 1ns/100ps
module scc_cache_asserts (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_req_valid,
    input wire logic        i_mem_ready,
    input wire logic        i_mem_rvalid,
    input wire logic [31:0] i_mem_rdata,
    input wire logic        i_disp_ready,
    input wire logic        o_req_ready,
    input wire logic        o_mem_rd,
    input wire logic [31:0] o_mem_addr,
    input wire logic [6:0]  o_mem_words,
    input wire logic        o_disp_valid,
    input wire logic [5:0]  o_disp_slot,
    input wire logic        o_disp_hit,
    input wire logic        o_wr_valid,
    input wire logic [6:0]  o_wr_word,
    input wire logic [31:0] o_wr_data
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_mem_hold: assert property (
        o_mem_rd && !i_mem_ready |=> o_mem_rd && $stable(o_mem_addr))
        else $error("fetch command dropped early");
    a_wr_word: assert property (
        i_mem_rvalid |=> o_wr_valid && o_wr_data == $past(i_mem_rdata))
        else $error("fetched word not stored");
    a_wr_cause: assert property (
        o_wr_valid |-> $past(i_mem_rvalid))
        else $error("store without fetched word");
    a_ctx_len: assert property (
        o_mem_rd |-> o_mem_words == 7'h50)
        else $error("fetch length wrong");
    a_last_disp: assert property (
        o_wr_valid && o_wr_word == 7'h4f |-> ##[0:1] o_disp_valid && !o_disp_hit)
        else $error("no dispatch after last word");
    a_disp_hold: assert property (
        o_disp_valid && !i_disp_ready |=> o_disp_valid && $stable(o_disp_slot))
        else $error("dispatch dropped early");
    a_one_req: assert property (
        o_disp_valid || o_mem_rd |-> !o_req_ready)
        else $error("request taken while busy");
    a_take_busy: assert property (
        i_req_valid && o_req_ready |=> !o_req_ready)
        else $error("ready stayed high after take");
    a_hit_quiet: assert property (
        o_disp_valid && o_disp_hit |-> !o_mem_rd && !o_wr_valid)
        else $error("memory traffic on hit");

    c_hit: cover property (o_disp_valid && o_disp_hit && i_disp_ready);
    c_miss: cover property (o_disp_valid && !o_disp_hit && i_disp_ready);
    c_stall: cover property (o_mem_rd && !i_mem_ready);
endmodule : scc_cache_asserts

// ===== scc_mem_model.sv
// scc_mem_model: host memory answering context fetches
// assumes one read command at a time, 80 words per context
`timescale 1ns/100ps
module scc_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_rd,
    input  wire logic [31:0] i_addr,
    output logic             o_ready,
    output logic             o_rvalid,
    output logic      [31:0] o_rdata
);
    logic [31:0] base_q;
    int          left_q;
    // accept after a random wait, then stream with random gaps
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ready  <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0;
            base_q   <= 32'h0;
            left_q   <= 0;
        end
        else
        begin
            o_ready  <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata  <= ~o_rdata; // idle data keeps changing
            if (i_rd && !o_ready && left_q == 0 && $urandom_range(2, 0) == 0)
            begin
                o_ready <= 1'b1;
                base_q  <= i_addr;
                left_q  <= 80;
            end
            else if (left_q != 0 && $urandom_range(3, 0) != 0)
            begin
                o_rvalid <= 1'b1;
                o_rdata  <= base_q ^ (32'(80 - left_q) * 32'h00010203);
                left_q   <= left_q - 1;
            end
        end
    end
endmodule : scc_mem_model

// ===== tb_top.sv
// tb_top: random and corner tests of the context cache
// assumes scc_mem_model as host memory; bench is requester and engine
`timescale 1ns/100ps
module tb_top;
    logic i_clk, i_rst_b, i_req_valid, i_mem_ready, i_mem_rvalid;
    logic i_disp_ready, i_done_valid, o_req_ready, o_mem_rd;
    logic o_disp_valid, o_disp_hit, o_wr_valid;
    logic [31:0] i_req_ptr, i_mem_rdata, o_mem_addr, o_wr_data, last_addr;
    logic [15:0] i_req_id;
    logic [1:0]  i_req_flags;
    logic [5:0]  i_done_slot, o_disp_slot, o_wr_slot, wr_slot;
    logic [6:0]  o_mem_words, o_wr_word;
    logic [5:0]  slot_of [logic [14:0]];
    bit          seen [30];
    int          mismatches = 0, check_count = 0, fetches = 0, cycles = 0;

    scc_cache dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
        .i_req_ptr(i_req_ptr), .i_req_id(i_req_id), .i_req_flags(i_req_flags),
        .i_mem_ready(i_mem_ready), .i_mem_rvalid(i_mem_rvalid),
        .i_mem_rdata(i_mem_rdata), .i_disp_ready(i_disp_ready),
        .i_done_valid(i_done_valid), .i_done_slot(i_done_slot),
        .o_req_ready(o_req_ready), .o_mem_rd(o_mem_rd),
        .o_mem_addr(o_mem_addr), .o_mem_words(o_mem_words),
        .o_disp_valid(o_disp_valid), .o_disp_slot(o_disp_slot),
        .o_disp_hit(o_disp_hit), .o_wr_valid(o_wr_valid),
        .o_wr_slot(o_wr_slot), .o_wr_word(o_wr_word), .o_wr_data(o_wr_data)
    );
    scc_mem_model u_mem (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_rd(o_mem_rd),
        .i_addr(o_mem_addr), .o_ready(i_mem_ready),
        .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata)
    );

    always #20 i_clk = ~i_clk;

    function automatic logic [31:0] exp_word(logic [31:0] a, logic [6:0] i);
        return a ^ (32'(i) * 32'h00010203);
    endfunction : exp_word

    function automatic logic [15:0] cid(int k, logic p);
        return {p, 7'h0, 4'(k), 4'hf};
    endfunction : cid

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict;
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // one request; kind 0 miss, 1 hit, 2 no dispatch
    task automatic req(input logic [15:0] id, input logic [1:0] fl,
                       input int kind);
        int f0;
        int n;
        f0 = fetches;
        n = 0;
        i_req_id = id;
        i_req_ptr = {1'b0, id[14:0], 16'h0};
        i_req_flags = fl;
        i_req_valid = 1'b1;
        while (o_req_ready !== 1'b1)
            @(negedge i_clk);
        @(negedge i_clk);
        i_req_valid = 1'b0;
        while (o_disp_valid !== 1'b1 && o_req_ready !== 1'b1 && n < 300)
        begin
            @(negedge i_clk);
            n++;
        end
        check(32'(o_disp_valid), 32'(kind != 2));
        if (kind == 1)
            check(32'(n <= 2), 32'h1);
        if (o_disp_valid === 1'b1)
        begin
            check(32'(o_disp_hit), 32'(kind == 1));
            check(32'(o_disp_slot[5:2]), 32'(id[3:0]));
            if (kind == 0)
                check(32'(o_disp_slot), 32'(wr_slot));
            if (kind == 1)
                check(32'(o_disp_slot), 32'(slot_of[id[14:0]]));
            slot_of[id[14:0]] = o_disp_slot;
            repeat ($urandom_range(2, 0)) @(negedge i_clk);
            i_disp_ready = 1'b1;
            @(negedge i_clk);
            i_disp_ready = 1'b0;
            i_done_slot = slot_of[id[14:0]];
            i_done_valid = 1'b1;
            @(negedge i_clk);
            i_done_valid = 1'b0;
        end
        while (o_req_ready !== 1'b1)
            @(negedge i_clk);
        check(32'(fetches - f0), 32'(kind == 0));
    endtask : req

    // count fetches, check stored words, cut a hang short
    always @(negedge i_clk)
    begin
        cycles++;
        if (o_mem_rd === 1'b1 && i_mem_ready === 1'b1)
        begin
            fetches++;
            last_addr = o_mem_addr;
        end
        if (o_wr_valid === 1'b1)
        begin
            wr_slot = o_wr_slot;
            check(o_wr_data, exp_word(last_addr, o_wr_word));
        end
        if (cycles > 40000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        int j;
        i_clk = 1'b0;
        i_rst_b = 1'b0;
        i_req_valid = 1'b0;
        i_req_ptr = 32'h0;
        i_req_id = 16'h0;
        i_req_flags = 2'h0;
        i_disp_ready = 1'b0;
        i_done_valid = 1'b0;
        i_done_slot = 6'h0;
        void'($urandom(32'h093719f3));
        repeat (5) @(negedge i_clk);
        i_rst_b = 1'b1;
        // random traffic, two contexts per set in sets 0 to 14
        for (int k = 0; k < 60; k++)
        begin
            j = $urandom_range(29, 0);
            req({8'h0, 4'(j / 15), 4'(j % 15)}, 2'h0, seen[j] ? 1 : 0);
            seen[j] = 1'b1;
        end
        // set 15: fourth pin is dropped, so it is the victim
        for (int k = 0; k < 4; k++)
            req(cid(k, 1'b1), 2'h0, 0);
        req(cid(4, 1'b0), 2'h0, 0);
        check(32'(slot_of[15'(cid(4, 1'b0))]), 32'(slot_of[15'(cid(3, 1'b0))]));
        req(cid(3, 1'b1), 2'h0, 0);
        req(cid(4, 1'b0), 2'h0, 0);
        for (int k = 0; k < 3; k++)
            req(cid(k, 1'b0), 2'h0, 1);
        // forced removal of a pinned entry, then of an absent one
        req(cid(0, 1'b0), 2'h1, 2);
        req(cid(0, 1'b1), 2'h0, 0);
        req(16'h7fff, 2'h3, 2);
        req(cid(1, 1'b0), 2'h0, 1);
        req(cid(1, 1'b0), 2'h2, 2);
        req(cid(2, 1'b0), 2'h0, 1);
        give_verdict();
    end
endmodule : tb_top

bind scc_cache scc_cache_asserts u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
    .i_mem_ready(i_mem_ready), .i_mem_rvalid(i_mem_rvalid),
    .i_mem_rdata(i_mem_rdata), .i_disp_ready(i_disp_ready),
    .o_req_ready(o_req_ready), .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr), .o_mem_words(o_mem_words),
    .o_disp_valid(o_disp_valid), .o_disp_slot(o_disp_slot),
    .o_disp_hit(o_disp_hit), .o_wr_valid(o_wr_valid),
    .o_wr_word(o_wr_word), .o_wr_data(o_wr_data)
);
